/* File: mrs_regs.vh */
// Constants for the reset filter and sequencer
`ifndef MRS_REGS_VH
`define MRS_REGS_VH
`define MRS_CLK_NS 8'h08
`define MRS_FILT_CYC 3'h4
`define MRS_STRETCH_CYC 5'h12
`define MRS_FETCH_DLY_CYC 4'h7
`define MRS_RESET_VECTOR 16'h000c
`define MRS_POR_TIME_NS 24'h4c4b40
// Power-on time over the clock period, sized to the 20-bit drive counter
`define MRS_POR_CYC 20'h98968
`endif

/* File: mrs_sync2.v */
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module mrs_sync2 #(
  parameter [0:0] RESET_VAL = 1'b1
) (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_async,
  output reg o_sync
);
  reg meta_q;
  // First flop feeds only the second
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      meta_q <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // mrs_sync2
`default_nettype wire

/* File: mrs_reset_seq.v */
// Reset source merge, external reset filter, stretcher and strobe sequencing
// What this block does
// - Internal reset comes from power-on, watchdog, stop recovery, low voltage or pin.
// - Power-on and watchdog resets pull the reset pin low for the power-on interval.
// - Reset pin has an internal pull-up so it idles high.
// - Nothing inside the device can block an external reset request.
// - Pin low shorter than four clocks causes no reset.
// - Reset latched sixth clock, held for the request length plus 18 clocks after it ends.
// - Data strobe held low throughout reset.
// - Address strobe toggles once every clock period during reset.
// - Fetch starts at vector 000c, 5 to 10 clocks after reset release.
// - Power-on reset drives the pin for about 5 ms.
`timescale 1ns/100ps
`default_nettype none
`include "mrs_regs.vh"
module mrs_reset_seq #(
  parameter [19:0] POR_CYC = `MRS_POR_CYC
) (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_por_req,
  input wire i_wdt_timeout,
  input wire i_stop_recover,
  input wire i_low_voltage,
  input wire i_init_pin,
  output reg o_init_pin,
  output reg o_init_pin_oe_n,
  output reg o_init_pin_pullup,
  output reg o_internal_init_pulse,
  output reg o_data_strobe_n,
  output reg o_address_strobe_n,
  output reg o_fetch_start,
  output reg [15:0] o_fetch_addr
);
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_RESET = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  wire pin_s;
  wire por_s;
  wire wdt_s;
  wire stop_s;
  wire lv_s;
  reg [1:0] state_q;
  reg [2:0] filt_q;
  reg [2:0] lead_q;
  reg ext_qual_q;
  reg [4:0] stretch_q;
  reg [19:0] por_q;
  reg [3:0] fetch_q;
  wire drive_req;
  wire int_src;
  wire hold;
  wire in_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise every source that comes from outside this clock
  // The pin synchroniser resets high so a release never looks like a request
  mrs_sync2 #(.RESET_VAL(1'b1)) u_pin (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_async(i_init_pin), .o_sync(pin_s));
  mrs_sync2 #(.RESET_VAL(1'b0)) u_por (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_async(i_por_req), .o_sync(por_s));
  mrs_sync2 #(.RESET_VAL(1'b0)) u_wdt (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_async(i_wdt_timeout), .o_sync(wdt_s));
  mrs_sync2 #(.RESET_VAL(1'b0)) u_stop (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_async(i_stop_recover), .o_sync(stop_s));
  mrs_sync2 #(.RESET_VAL(1'b0)) u_lv (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_async(i_low_voltage), .o_sync(lv_s));

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive interval for power-on and watchdog resets. The count reloads
  // while the request stands, so the pin stays low for the whole request
  // plus the power-on interval.
  assign drive_req = por_s | wdt_s;
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      por_q <= 20'h00000;
    end else if (drive_req) begin
      por_q <= POR_CYC;
    end else if (por_q != 20'h00000) begin
      por_q <= por_q - 20'h00001;
    end
  end

  // Open-drain: drive low only, enable is active low while driving
  // The filter sees this pull as well, which only lengthens the reset
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_init_pin <= 1'b0;
      o_init_pin_oe_n <= 1'b1;
      o_init_pin_pullup <= 1'b1;
    end else begin
      o_init_pin <= 1'b0;
      o_init_pin_oe_n <= ~(drive_req | (por_q != 20'h00000));
      o_init_pin_pullup <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin filter: four low clocks qualify a request, a high before that clears
  // the count. Once qualified the request is latched even if the pin lets go,
  // so a pulse of exactly four clocks still resets. Nothing gates this path.
  // Timing in edges after the synchronised pin goes low: four fill the
  // filter, the fifth arms the latch, the sixth sets the qualified request
  // and the internal pulse follows one edge later. The synchroniser in
  // front adds two more edges of latency.
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      filt_q <= 3'h0;
      ext_qual_q <= 1'b0;
      lead_q <= 3'h0;
    end else begin
      if (filt_q != `MRS_FILT_CYC) begin
        if (pin_s) begin
          filt_q <= 3'h0;
        end else begin
          filt_q <= filt_q + 3'h1;
        end
      end else if (lead_q != 3'h1) begin
        lead_q <= lead_q + 3'h1; // Fifth clock after detection
      end else if (!ext_qual_q) begin
        ext_qual_q <= 1'b1;
      end else if (pin_s) begin
        // Request over; the stretcher carries the pulse from here
        filt_q <= 3'h0;
        lead_q <= 3'h0;
        ext_qual_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset source merge and stretch counter
  assign int_src = ext_qual_q | drive_req | (por_q != 20'h00000) | stop_s | lv_s;
  assign hold = int_src | (stretch_q != 5'h00);

  // Loaded while any source is active, so the pulse outlasts the last source
  // by 18 clocks; reset loads it too, giving power-up the same minimum
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      stretch_q <= `MRS_STRETCH_CYC - 5'h01;
    end else if (int_src) begin
      stretch_q <= `MRS_STRETCH_CYC - 5'h01;
    end else if (stretch_q != 5'h00) begin
      stretch_q <= stretch_q - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: reset, post-release wait, run. A new source during the wait
  // sends it back to reset, so a fetch never starts under an active source.
  // The wait count gives a fetch six clocks after the pulse drops.
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_q <= ST_RESET;
      fetch_q <= 4'h0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (int_src) begin
            state_q <= ST_RESET;
          end
        end
        ST_RESET: begin
          fetch_q <= 4'h0;
          if (!hold) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (int_src) begin
            state_q <= ST_RESET;
          end else if (fetch_q == `MRS_FETCH_DLY_CYC - 4'h1) begin
            state_q <= ST_RUN;
          end else begin
            fetch_q <= fetch_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset is in progress while the sequencer holds reset or a source is
  // active; the pulse and both bus strobes follow this one term so they move together (the pin drive follows the drive request)
  assign in_reset = (state_q == ST_RESET) | int_src;

  // Internal reset pulse and fetch start; the vector is fixed
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_internal_init_pulse <= 1'b1;
      o_fetch_start <= 1'b0;
      o_fetch_addr <= `MRS_RESET_VECTOR;
    end else begin
      o_internal_init_pulse <= in_reset;
      o_fetch_start <= (state_q == ST_WAIT) && !int_src &&
        (fetch_q == `MRS_FETCH_DLY_CYC - 4'h1);
      o_fetch_addr <= `MRS_RESET_VECTOR;
    end
  end

  // Bus strobes; the address strobe can only toggle once per clock here,
  // so half-period rate becomes one edge each clock. Driving both from the
  // same term as the pulse keeps them in step on the first reset clock.
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_data_strobe_n <= 1'b0;
      o_address_strobe_n <= 1'b1;
    end else if (in_reset) begin
      o_data_strobe_n <= 1'b0;
      o_address_strobe_n <= ~o_address_strobe_n;
    end else begin
      o_data_strobe_n <= 1'b1;
      o_address_strobe_n <= 1'b1;
    end
  end
endmodule // mrs_reset_seq
`default_nettype wire

/* File: mrs_pin_drv.sv */
// Open-drain reset supervisor model on the shared reset pin
`timescale 1ns/100ps
`default_nettype none
module mrs_pin_drv(
  input wire logic i_pull,
  input wire logic i_oe_n,
  input wire logic i_dout,
  input wire logic i_pullup,
  output logic o_pin
);
  // Wired line: each party may only pull low; without the pull-up an idle line reads low
  assign o_pin = !(i_pull || (!i_oe_n && !i_dout)) && i_pullup;
endmodule // mrs_pin_drv
`default_nettype wire

/* File: mrs_reset_seq_sva.sv */
// Assertion checker for the reset filter and sequencer
`timescale 1ns/100ps
`default_nettype none
module mrs_reset_seq_sva(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_por_req,
  input wire logic i_wdt_timeout,
  input wire logic i_stop_recover,
  input wire logic i_low_voltage,
  input wire logic i_init_pin,
  input wire logic o_init_pin,
  input wire logic o_init_pin_oe_n,
  input wire logic o_init_pin_pullup,
  input wire logic o_internal_init_pulse,
  input wire logic o_data_strobe_n,
  input wire logic o_address_strobe_n,
  input wire logic o_fetch_start,
  input wire logic [15:0] o_fetch_addr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // Long request and a short blip that is refused
  sequence s_req; $fell(i_init_pin) ##1 !i_init_pin[*7]; endsequence
  sequence s_blip; $fell(i_init_pin) ##1 !i_init_pin[*2] ##1 i_init_pin[*8]; endsequence
  property p_pu; o_init_pin_pullup; endproperty
  a_pu: assert property (p_pu) else $error("pull-up off");
  property p_drv; $rose(i_por_req || i_wdt_timeout) |-> ##3 !o_init_pin_oe_n && !o_init_pin; endproperty
  a_drv: assert property (p_drv) else $error("pin not pulled");
  property p_src; $rose(i_stop_recover || i_low_voltage) |-> ##[1:4] o_internal_init_pulse; endproperty
  a_src: assert property (p_src) else $error("source ignored");
  // Two sync edges plus six filter edges put the pulse two samples past the sequence end
  property p_req; s_req |-> ##[1:2] o_internal_init_pulse; endproperty
  a_req: assert property (p_req) else $error("pin request missed");
  property p_blip; !o_internal_init_pulse ##0 s_blip |-> !o_internal_init_pulse; endproperty
  a_blip: assert property (p_blip) else $error("glitch caused reset");
  property p_hold; $fell(o_internal_init_pulse) |-> $past(o_internal_init_pulse, 18); endproperty
  a_hold: assert property (p_hold) else $error("reset too short");
  property p_ds; o_internal_init_pulse |-> !o_data_strobe_n; endproperty
  a_ds: assert property (p_ds) else $error("data strobe high");
  // Past reset term skips the release edge, where both samples are reset values
  property p_as; o_internal_init_pulse && $past(o_internal_init_pulse) && $past(i_rstn)
    |-> o_address_strobe_n != $past(o_address_strobe_n); endproperty
  a_as: assert property (p_as) else $error("address strobe stuck");
  property p_fetch; $fell(o_internal_init_pulse) |-> ##[5:10] o_fetch_start; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch late");
  property p_vec; o_fetch_start |-> o_fetch_addr == 16'h000c; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
endmodule // mrs_reset_seq_sva
bind mrs_reset_seq mrs_reset_seq_sva chk_u(
  .i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn),
  .i_por_req(i_por_req),
  .i_wdt_timeout(i_wdt_timeout),
  .i_stop_recover(i_stop_recover),
  .i_low_voltage(i_low_voltage),
  .i_init_pin(i_init_pin),
  .o_init_pin(o_init_pin),
  .o_init_pin_oe_n(o_init_pin_oe_n),
  .o_init_pin_pullup(o_init_pin_pullup),
  .o_internal_init_pulse(o_internal_init_pulse),
  .o_data_strobe_n(o_data_strobe_n),
  .o_address_strobe_n(o_address_strobe_n),
  .o_fetch_start(o_fetch_start),
  .o_fetch_addr(o_fetch_addr)
);
`default_nettype wire

/* File: mrs_reset_seq_tb.sv */
// Self-checking testbench for the reset filter and sequencer
`timescale 1ns/100ps
`default_nettype none
module mrs_reset_seq_tb;
  logic clk = 0, rstn = 0, por = 0, wdt = 0, stp = 0, lv = 0, pull = 0;
  wire logic pin, dout, oe_n, pu, init, ds_n, as_n, fst;
  wire logic [15:0] fad;
  int error_cnt = 0, checks = 0;
  initial forever #4 clk = ~clk;
  mrs_pin_drv pin_u(.i_pull(pull), .i_oe_n(oe_n), .i_dout(dout), .i_pullup(pu), .o_pin(pin));
  // Short power-on count keeps the run brief
  mrs_reset_seq #(.POR_CYC(20'h14)) dut_u(.i_sys_clk(clk), .i_rstn(rstn), .i_por_req(por),
    .i_wdt_timeout(wdt), .i_stop_recover(stp), .i_low_voltage(lv), .i_init_pin(pin), .o_init_pin(dout),
    .o_init_pin_oe_n(oe_n), .o_init_pin_pullup(pu), .o_internal_init_pulse(init), .o_data_strobe_n(ds_n),
    .o_address_strobe_n(as_n), .o_fetch_start(fst), .o_fetch_addr(fad));
  task test_done;
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  // Inputs move 1 ns after the edge so no race with the design's flops
  task cyc(input int n); repeat (n) @(posedge clk); #1; endtask
  task wait_fetch;
    int i;
    i = 0;
    // A watchdog reset also holds the pin, which the filter extends by its own latency
    while (fst !== 1'b1 && i < 80) begin cyc(1); i++; end
    chk("fetch", 1, fst);
    chk("vector", 16'h000c, fad);
    cyc(10);
    chk("init", 0, init);
  endtask
  task t_blip;
    pull = 1; cyc(3); pull = 0; cyc(1); pull = 1; cyc(3); pull = 0; cyc(12);
    chk("init", 0, init);
    // Exactly four clocks low is long enough and must reset
    pull = 1; cyc(4); pull = 0; cyc(12);
    chk("init", 1, init);
    wait_fetch;
  endtask
  task t_ext;
    logic s;
    pull = 1; cyc(9);
    chk("init", 1, init);
    chk("ds_n", 0, ds_n);
    s = as_n;
    cyc(1);
    chk("as_n", !s, as_n);
    cyc(30); pull = 0; cyc(18);
    chk("init", 1, init);
    wait_fetch;
  endtask
  task t_por;
    por = 1; cyc(5);
    chk("pin", 0, pin);
    por = 0; cyc(20);
    chk("oe_n", 0, oe_n);
    cyc(10);
    chk("oe_n", 1, oe_n);
    chk("pin", 1, pin);
    wait_fetch;
  endtask
  task t_src;
    for (int k = 0; k < 3; k++) begin
      {wdt, stp, lv} = 3'h4 >> k; cyc(6);
      chk("init", 1, init);
      {wdt, stp, lv} = 3'h0; wait_fetch;
    end
  endtask
  initial begin
    cyc(4); rstn = 1; cyc(40);
    chk("init", 0, init);
    t_blip; t_ext; t_por; t_src;
    test_done;
  end
  initial begin #200000; error_cnt++; test_done; end
endmodule // mrs_reset_seq_tb
`default_nettype wire
